// File: hw/drs_consts.svh
// Purpose: offsets, field positions, reset values and timing of the
//          reference / ramp / stop sequencer
// Assumes: word-addressed plain register port, 7 address bits
// Notes:   parameter set for motor 2 sits 0x20 above motor 1
`ifndef DRS_CONSTS_SVH
`define DRS_CONSTS_SVH

// ==================================================================
// parameter set slots (index inside one motor set)
`define DRS_P_METHOD    5'h00
`define DRS_P_RUNSRC    5'h01
`define DRS_P_REFSRC    5'h02
`define DRS_P_DETMS     5'h03
`define DRS_P_STOPMODE  5'h04
`define DRS_P_HOLDMS    5'h05
`define DRS_P_OFFMS     5'h06
`define DRS_P_MIXREF    5'h07
`define DRS_P_RAMPEN    5'h08
`define DRS_P_ACCSCALE  5'h09
`define DRS_P_ACCSW1    5'h0a
`define DRS_P_ACCSW2    5'h0b
`define DRS_P_ACCT1     5'h0c
`define DRS_P_ACCT2     5'h0d
`define DRS_P_ACCT3     5'h0e
`define DRS_P_ACCALT    5'h0f
`define DRS_P_DECSCALE  5'h10
`define DRS_P_DECSW1    5'h11
`define DRS_P_DECSW2    5'h12
`define DRS_P_DECT1     5'h13
`define DRS_P_DECT2     5'h14
`define DRS_P_DECT3     5'h15
`define DRS_P_DECALT    5'h16
`define DRS_P_MAXREF    5'h17
`define DRS_P_RATEDREF  5'h18

// ==================================================================
// global registers (word addresses)
`define DRS_A_KEY1      7'h40
`define DRS_A_KEY2      7'h41
`define DRS_A_KEY3      7'h42
`define DRS_A_SYSRST    7'h43
`define DRS_A_STATUS    7'h44
`define DRS_A_APPREF    7'h45
`define DRS_A_DIFUNC0   7'h48

// ==================================================================
// status fields, codes, reset values
`define DRS_S_OUTEN     3
`define DRS_S_METHOK    4
`define DRS_S_PKGOK     5
`define DRS_S_PKG       6
`define DRS_S_MOTOR     7
`define DRS_S_TUNED     8
`define DRS_DI_MOTOR    16'h000b
`define DRS_DI_ACCSW    16'h000c
`define DRS_PAR_RESET   16'h0000
`define DRS_TIME_X10    16'h000a
`define DRS_TIME_X1     16'h0001

// ==================================================================
// timing: control tick of 1 ms at an 8 ns clock
`define DRS_CLK_NS      8
`define DRS_TICK_NS     1000000
`define DRS_TICK_CYC    (`DRS_TICK_NS / `DRS_CLK_NS)
`define DRS_TICKS_PER_S 32'd1000

`endif

// File: hw/drs_pkg.sv
// Purpose: types of the reference / ramp / stop sequencer
// Assumes: constants live in drs_consts.svh
// Notes:   state codes are visible in the status register
package drs_pkg;

    // ==============================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_STOP = 3'b000,
        ST_RUN  = 3'b001,
        ST_DET  = 3'b010,
        ST_DEC  = 3'b011,
        ST_HOLD = 3'b100,
        ST_LOCK = 3'b101
    } drs_state_t;

    // ==============================================================
    // control methods and command sources
    typedef enum logic [1:0] {
        CM_VF_FREQ = 2'b00,
        CM_VF_SPD  = 2'b01,
        CM_SLV_SPD = 2'b10,
        CM_VEC_SPD = 2'b11
    } drs_method_t;

    typedef enum logic [1:0] {
        SRC_TERM = 2'b00,
        SRC_KEY  = 2'b01,
        SRC_COMM = 2'b10
    } drs_src_t;

endpackage : drs_pkg

// File: hw/drs_sequencer.sv
// Purpose: run/stop, reference source, ramp and stop sequencing
// Assumes: parameters written over the plain register port
// Notes:   reference units are arbitrary 16-bit speed/frequency steps
`timescale 1ns/1ps
`include "drs_consts.svh"

module drs_sequencer
    import drs_pkg::*;
#(
    parameter int TICK_CYC = `DRS_TICK_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [6:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata_r,
    // pins
    input  wire logic        digitalInputOne,
    input  wire logic [3:0]  diPins,
    // same-clock command sources
    input  wire logic        keyRun,
    input  wire logic        commRun,
    input  wire logic [15:0] termRef,
    input  wire logic [15:0] keyRef,
    input  wire logic [15:0] commRef,
    input  wire logic        tuneDone,
    // drive outputs
    output logic      [15:0] appliedRef_r,
    output logic             outEnable_r,
    output logic             operating_r,
    output logic             motorSel_r
);

    // ==============================================================
    // storage
    logic [15:0] parSet_r [0:63];
    logic [15:0] diFunc_r [0:3];
    logic [1:0]  key_r [0:2];
    logic        secondPkg_r;
    logic        pkgOk_r;
    logic [1:0]  tuned_r;
    logic        methodOk_r;
    drs_state_t  st_r;
    drs_state_t  stNxt;
    logic [15:0] tmr_r;
    logic [16:0] tickCnt_r;
    logic        tick_r;
    logic [31:0] acc_r;
    logic [15:0] pend_r;

    // ==============================================================
    // pin synchronisers
    logic [4:0] pinMeta_r;
    logic [4:0] pinSync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_r <= 5'h00;
            pinSync_r <= 5'h00;
        end else begin
            pinMeta_r <= {diPins, digitalInputOne};
            pinSync_r <= pinMeta_r;
        end
    end

    // ==============================================================
    // digital input functions
    logic [3:0] diMotor;
    logic [3:0] diAccSw;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_di
            assign diMotor[gi] = pinSync_r[gi+1] && diFunc_r[gi] == `DRS_DI_MOTOR;
            assign diAccSw[gi] = pinSync_r[gi+1] && diFunc_r[gi] == `DRS_DI_ACCSW;
        end
    endgenerate

    logic motorSel;
    logic altTime;
    assign motorSel = |diMotor;
    assign altTime  = |diAccSw;

    // active motor set lookup
    function automatic logic [15:0] par(input logic [4:0] idx);
        return parSet_r[{motorSel, idx}];
    endfunction : par

    // ==============================================================
    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 64; i++) begin
                parSet_r[i] <= `DRS_PAR_RESET;
            end
            for (int i = 0; i < 4; i++) begin
                diFunc_r[i] <= `DRS_PAR_RESET;
            end
            for (int i = 0; i < 3; i++) begin
                key_r[i] <= 2'h0;
            end
        end else if (regWr) begin
            if (!regAddr[6]) begin
                parSet_r[regAddr[5:0]] <= regWdata;
            end else if (regAddr >= `DRS_A_KEY1 && regAddr <= `DRS_A_KEY3) begin
                key_r[regAddr[1:0]] <= regWdata[1:0];
            end else if (regAddr[6:2] == `DRS_A_DIFUNC0 >> 2) begin
                diFunc_r[regAddr[1:0]] <= regWdata;
            end
        end
    end

    // ==============================================================
    // program package
    logic keysAgree;
    assign keysAgree = key_r[0] == key_r[1] && key_r[1] == key_r[2];

    always_ff @(posedge clk) begin
        if (rst) begin
            secondPkg_r <= 1'b0;
            pkgOk_r     <= 1'b1;
        end else if (regWr && regAddr == `DRS_A_SYSRST && regWdata[0]) begin
            secondPkg_r <= key_r[0][0];
            pkgOk_r     <= keysAgree && !key_r[0][1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tuned_r <= 2'b00;
        end else if (tuneDone) begin
            tuned_r[motorSel] <= 1'b1;
        end
    end

    // ==============================================================
    // method check
    drs_method_t method;
    logic        methodOk;
    assign method = drs_method_t'(par(`DRS_P_METHOD) & 16'h0003);

    always_comb begin
        case (method)
            CM_VF_FREQ: methodOk = 1'b1;
            CM_VF_SPD:  methodOk = 1'b1;
            CM_SLV_SPD: methodOk = !secondPkg_r && tuned_r[motorSel];
            CM_VEC_SPD: methodOk = secondPkg_r && tuned_r[motorSel];
            default:    methodOk = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            methodOk_r <= 1'b0;
            motorSel_r <= 1'b0;
        end else begin
            methodOk_r <= methodOk && pkgOk_r;
            motorSel_r <= motorSel;
        end
    end

    // ==============================================================
    // command and reference sources
    logic        runCmd;
    logic [15:0] selRef;

    always_comb begin
        case (par(`DRS_P_RUNSRC))
            16'h0000: runCmd = pinSync_r[0];
            16'h0001: runCmd = keyRun;
            16'h0002: runCmd = commRun;
            default:  runCmd = 1'b0;
        endcase
        case (par(`DRS_P_REFSRC))
            16'h0000: selRef = termRef;
            16'h0001: selRef = keyRef;
            16'h0002: selRef = commRef;
            default:  selRef = 16'h0000;
        endcase
    end

    // ==============================================================
    // control tick
    always_ff @(posedge clk) begin
        if (rst) begin
            tickCnt_r <= 17'h00000;
            tick_r    <= 1'b0;
        end else if (tickCnt_r == 17'(TICK_CYC - 1)) begin
            tickCnt_r <= 17'h00000;
            tick_r    <= 1'b1;
        end else begin
            tickCnt_r <= tickCnt_r + 17'h00001;
            tick_r    <= 1'b0;
        end
    end

    // ==============================================================
    // stop sequencer
    logic [15:0] stopMode;
    assign stopMode = par(`DRS_P_STOPMODE);

    always_comb begin
        stNxt = st_r;
        case (st_r)
            ST_STOP: begin
                if (runCmd && methodOk_r) begin
                    stNxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!runCmd) begin
                    stNxt = ST_DET;
                end
            end
            ST_DET: begin
                if (runCmd) begin
                    stNxt = ST_RUN;
                end else if (tmr_r >= par(`DRS_P_DETMS)) begin
                    stNxt = (stopMode == 16'h0001) ? ST_LOCK : ST_DEC;
                end
            end
            ST_DEC: begin
                if (runCmd) begin
                    stNxt = ST_RUN;
                end else if (stopMode == 16'h0002 &&
                             appliedRef_r < par(`DRS_P_MIXREF)) begin
                    stNxt = ST_LOCK;
                end else if (appliedRef_r == 16'h0000) begin
                    stNxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (runCmd) begin
                    stNxt = ST_RUN;
                end else if (tmr_r >= par(`DRS_P_HOLDMS)) begin
                    stNxt = ST_STOP;
                end
            end
            ST_LOCK: begin
                if (tmr_r >= par(`DRS_P_OFFMS)) begin
                    stNxt = ST_STOP;
                end
            end
            default: stNxt = ST_STOP;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= ST_STOP;
        end else begin
            st_r <= stNxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || stNxt != st_r) begin
            tmr_r <= 16'h0000;
        end else if (tick_r && tmr_r != 16'hffff) begin
            tmr_r <= tmr_r + 16'h0001;
        end
    end

    // output stage follows the next state so the cut lands at once
    logic outOn;
    assign outOn = stNxt == ST_RUN || stNxt == ST_DET ||
                   stNxt == ST_DEC || stNxt == ST_HOLD;

    always_ff @(posedge clk) begin
        if (rst) begin
            outEnable_r <= 1'b0;
            operating_r <= 1'b0;
        end else begin
            outEnable_r <= outOn;
            operating_r <= outOn;
        end
    end

    // ==============================================================
    // ramp segment selection
    logic [15:0] maxRef;
    logic [15:0] target;
    logic        goUp;
    logic [15:0] segTime;
    logic [15:0] segSpan;
    logic [15:0] segScale;
    logic [31:0] denom;

    assign maxRef = par(`DRS_P_MAXREF);
    assign target = (st_r == ST_RUN || st_r == ST_DET) ?
                    ((selRef > maxRef) ? maxRef : selRef) : 16'h0000;
    assign goUp   = target > appliedRef_r;

    always_comb begin
        if (goUp) begin
            segScale = |(par(`DRS_P_ACCSCALE) & 16'h0001) ? `DRS_TIME_X10 : `DRS_TIME_X1;
            if (altTime) begin
                segTime = par(`DRS_P_ACCALT);
                segSpan = par(`DRS_P_RATEDREF);
            end else if (appliedRef_r < par(`DRS_P_ACCSW1)) begin
                segTime = par(`DRS_P_ACCT1);
                segSpan = par(`DRS_P_ACCSW1);
            end else if (appliedRef_r < par(`DRS_P_ACCSW2)) begin
                segTime = par(`DRS_P_ACCT2);
                segSpan = par(`DRS_P_ACCSW2) - par(`DRS_P_ACCSW1);
            end else begin
                segTime = par(`DRS_P_ACCT3);
                segSpan = maxRef - par(`DRS_P_ACCSW2);
            end
        end else begin
            segScale = |(par(`DRS_P_DECSCALE) & 16'h0001) ? `DRS_TIME_X10 : `DRS_TIME_X1;
            if (altTime) begin
                segTime = par(`DRS_P_DECALT);
                segSpan = par(`DRS_P_RATEDREF);
            end else if (appliedRef_r > par(`DRS_P_DECSW2)) begin
                segTime = par(`DRS_P_DECT1);
                segSpan = maxRef - par(`DRS_P_DECSW2);
            end else if (appliedRef_r > par(`DRS_P_DECSW1)) begin
                segTime = par(`DRS_P_DECT2);
                segSpan = par(`DRS_P_DECSW2) - par(`DRS_P_DECSW1);
            end else begin
                segTime = par(`DRS_P_DECT3);
                segSpan = par(`DRS_P_DECSW1);
            end
        end
    end

    // ticks for one segment: seconds x scale x ticks per second
    assign denom = 32'(segTime * segScale) * `DRS_TICKS_PER_S;

    // ==============================================================
    // ramp step accumulator
    // span is added once per tick and drained one unit per clock, so
    // a segment may not ask for more units per tick than TICK_CYC - 1
    logic rampOn;
    assign rampOn = |(par(`DRS_P_RAMPEN) & 16'h0001) && denom != 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst || !rampOn || target == appliedRef_r) begin
            acc_r  <= 32'h00000000;
            pend_r <= 16'h0000;
        end else if (tick_r) begin
            acc_r  <= acc_r + {16'h0000, segSpan};
            pend_r <= 16'h0000;
        end else if (acc_r >= denom && pend_r != 16'hffff) begin
            acc_r  <= acc_r - denom;
            pend_r <= pend_r + 16'h0001;
        end
    end

    // ==============================================================
    // applied reference
    logic [16:0] upSum;
    logic [16:0] downLim;
    assign upSum   = {1'b0, appliedRef_r} + {1'b0, pend_r};
    assign downLim = {1'b0, target} + {1'b0, pend_r};

    always_ff @(posedge clk) begin
        if (rst) begin
            appliedRef_r <= 16'h0000;
        end else if (!outOn) begin
            appliedRef_r <= 16'h0000;
        end else if (!rampOn) begin
            appliedRef_r <= target;
        end else if (tick_r) begin
            if (goUp) begin
                appliedRef_r <= (upSum >= {1'b0, target}) ? target : upSum[15:0];
            end else if (downLim >= {1'b0, appliedRef_r}) begin
                appliedRef_r <= target;
            end else begin
                appliedRef_r <= appliedRef_r - pend_r;
            end
        end
    end

    // ==============================================================
    // register reads, data valid the cycle after the strobe
    logic [15:0] status;
    assign status = {6'h00, tuned_r, motorSel_r, secondPkg_r, pkgOk_r,
                     methodOk_r, outEnable_r, st_r};

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata_r <= 16'h0000;
        end else if (regRd) begin
            if (!regAddr[6]) begin
                regRdata_r <= parSet_r[regAddr[5:0]];
            end else if (regAddr >= `DRS_A_KEY1 && regAddr <= `DRS_A_KEY3) begin
                regRdata_r <= {14'h0000, key_r[regAddr[1:0]]};
            end else if (regAddr == `DRS_A_STATUS) begin
                regRdata_r <= status;
            end else if (regAddr == `DRS_A_APPREF) begin
                regRdata_r <= appliedRef_r;
            end else if (regAddr[6:2] == `DRS_A_DIFUNC0 >> 2) begin
                regRdata_r <= diFunc_r[regAddr[1:0]];
            end else begin
                regRdata_r <= 16'h0000;
            end
        end else begin
            regRdata_r <= 16'h0000;
        end
    end

endmodule : drs_sequencer

// File: dv/drs_seq_properties.sv
// Purpose: port-level properties of the sequencer
// Assumes: only the top ports are visible
// Notes:   bound to every sequencer instance below
`timescale 1ns/1ps
`include "drs_consts.svh"
module drs_seq_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register port
    input wire logic [6:0]  regAddr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata_r,
    // run inputs
    input wire logic        digitalInputOne,
    input wire logic        keyRun,
    input wire logic        commRun,
    // drive outputs
    input wire logic [15:0] appliedRef_r,
    input wire logic        outEnable_r,
    input wire logic        operating_r,
    input wire logic        motorSel_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==============================================================
    // steps
    sequence s_rd(a);
        regRd && regAddr == a;
    endsequence
    sequence s_stop;
        $fell(outEnable_r);
    endsequence

    // ==============================================================
    // properties
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdata_r == 16'h0000)
        else $error("read data not zero outside a read");
    a_rd_appref: assert property (s_rd(`DRS_A_APPREF) |=> regRdata_r == $past(appliedRef_r))
        else $error("applied reference readback differs");
    a_rd_status_bits: assert property (s_rd(`DRS_A_STATUS) |=>
        regRdata_r[3] == $past(outEnable_r) && regRdata_r[7] == $past(motorSel_r))
        else $error("status bits differ from outputs");
    a_rd_unmapped: assert property (s_rd(7'h7f) |=> regRdata_r == 16'h0000)
        else $error("unmapped read not zero");
    a_op_with_out: assert property (operating_r == outEnable_r)
        else $error("operating and output enable differ");
    a_idle_ref_zero: assert property (!outEnable_r && !$past(outEnable_r) |->
        appliedRef_r == 16'h0000)
        else $error("reference not zero while stopped");
    a_start_has_cause: assert property ($rose(outEnable_r) |-> $past(keyRun)
        || $past(commRun) || $past(digitalInputOne, 2) || $past(digitalInputOne, 3)
        || $past(digitalInputOne, 4))
        else $error("output enabled without a run command");
    a_stop_ref_zero: assert property (s_stop |-> ##[0:1] appliedRef_r == 16'h0000)
        else $error("reference left after stop");
    a_stop_stays_off: assert property (s_stop |-> !outEnable_r [*2])
        else $error("output back on right after stop");
endmodule : drs_seq_properties

bind drs_sequencer drs_seq_properties props (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regRd(regRd), .regRdata_r(regRdata_r),
    .digitalInputOne(digitalInputOne), .keyRun(keyRun), .commRun(commRun),
    .appliedRef_r(appliedRef_r), .outEnable_r(outEnable_r), .operating_r(operating_r),
    .motorSel_r(motorSel_r));

// File: dv/drs_cmd_model.sv
// Purpose: command sources in front of the sequencer
// Assumes: src 0 terminal, 1 keypad, 2 serial link
// Notes:   unselected reference words toggle every cycle
`timescale 1ns/1ps
module drs_cmd_model (
    // bench side
    input wire logic        clk,
    input wire logic [1:0]  src,
    input wire logic        run,
    input wire logic [15:0] refVal,
    // toward the sequencer
    output logic            digitalInputOne,
    output logic            keyRun,
    output logic            commRun,
    output logic [15:0]     termRef,
    output logic [15:0]     keyRef,
    output logic [15:0]     commRef
);
    logic [15:0] junk_r;
    initial begin
        junk_r = 16'h5a5a;
        {digitalInputOne, keyRun, commRun} = 3'h0;
        {termRef, keyRef, commRef} = {3{16'h0000}};
    end
    // only the chosen source is live
    always @(posedge clk) begin
        junk_r <= ~junk_r;
        digitalInputOne <= run && src == 2'd0;
        keyRun <= run && src == 2'd1;
        commRun <= run && src == 2'd2;
        termRef <= (src == 2'd0) ? refVal : junk_r;
        keyRef <= (src == 2'd1) ? refVal : junk_r;
        commRef <= (src == 2'd2) ? refVal : ~junk_r;
    end
endmodule : drs_cmd_model

// File: dv/tb.sv
// Purpose: self-checking bench of the sequencer
// Assumes: control tick shortened to 20 cycles
// Notes:   expectations from a small integer model
`timescale 1ns/1ps
`include "drs_consts.svh"
module tb;
    localparam int TICK = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [6:0]  regAddr = 7'h00;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [3:0]  diPins = 4'h0;
    logic        tuneDone = 1'b0;
    logic [1:0]  src = 2'd1;
    logic        run = 1'b0;
    logic [15:0] refVal = 16'h0000;
    logic        keyRun, commRun, digitalInputOne, outEnable_r, operating_r, motorSel_r;
    logic [15:0] termRef, keyRef, commRef, appliedRef_r, regRdata_r, st, r;
    int          errCount = 0;
    int          samplesChecked = 0;
    int          n;

    always #4 clk = ~clk;

    drs_cmd_model cmd (.clk(clk), .src(src), .run(run), .refVal(refVal),
        .digitalInputOne(digitalInputOne), .keyRun(keyRun), .commRun(commRun),
        .termRef(termRef), .keyRef(keyRef), .commRef(commRef));
    drs_sequencer #(.TICK_CYC(TICK)) uut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
        .digitalInputOne(digitalInputOne), .diPins(diPins), .keyRun(keyRun),
        .commRun(commRun), .termRef(termRef), .keyRef(keyRef), .commRef(commRef),
        .tuneDone(tuneDone), .appliedRef_r(appliedRef_r), .outEnable_r(outEnable_r),
        .operating_r(operating_r), .motorSel_r(motorSel_r));

    // ==============================================================
    // model and tasks
    function automatic logic okM(input int p, input int m);
        okM = (m < 2) || (m == 2 + p);
    endfunction : okM

    task automatic testDone();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : testDone

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdata_r;
    endtask : rd

    task automatic drive(input logic [1:0] s, input logic rn, input logic [15:0] v);
        @(posedge clk);
        src <= s;
        run <= rn;
        refVal <= v;
    endtask : drive

    // bounded wait; a run-out is a mismatch and ends the run
    task automatic waitOut(input logic lvl, input int lim);
        n = 0;
        while (outEnable_r !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                chk({15'h0, outEnable_r}, {15'h0, lvl});
                testDone();
            end
        end
    endtask : waitOut

    task automatic ramp(input logic [15:0] sc, input int ex, input int tol);
        wr({2'b00, `DRS_P_ACCSCALE}, sc);
        drive(2'd1, 1'b1, 16'hffff);
        waitOut(1'b1, 8);
        repeat (50 * TICK) @(posedge clk);
        @(negedge clk);
        chk(16'(appliedRef_r >= 16'(ex - tol) && appliedRef_r <= 16'(ex + tol)), 16'h1);
        drive(2'd1, 1'b0, 16'hffff);
        waitOut(1'b0, 8 * TICK);
    endtask : ramp

    // ==============================================================
    // sequence
    initial begin
        n = $urandom(32'h24d1a9ff);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`DRS_A_STATUS, st);
        chk({9'h0, st[6:0]}, 16'h0030);
        r = 16'($urandom);
        wr({2'b01, `DRS_P_MIXREF}, r);
        wr(`DRS_A_STATUS, 16'hffff);
        rd({2'b01, `DRS_P_MIXREF}, st);
        chk(st, r);
        rd(7'h7f, st);
        chk(st, 16'h0000);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 3; k++) begin
                wr(7'(`DRS_A_KEY1 + k), 16'(p));
            end
            wr(`DRS_A_SYSRST, 16'h0001);
            drive(2'd1, 1'b0, 16'h0);
            tuneDone <= 1'b1;
            @(posedge clk);
            tuneDone <= 1'b0;
            for (int m = 0; m < 4; m++) begin
                wr({2'b00, `DRS_P_METHOD}, 16'(m));
                rd(`DRS_A_STATUS, st);
                chk({15'h0, st[4]}, {15'h0, okM(p, m)});
                chk({15'h0, st[6]}, 16'(p));
            end
        end
        wr(`DRS_A_KEY2, 16'h0000);
        wr(`DRS_A_SYSRST, 16'h0001);
        rd(`DRS_A_STATUS, st);
        chk({15'h0, st[5]}, 16'h0000);
        wr(`DRS_A_KEY2, 16'h0001);
        wr(`DRS_A_SYSRST, 16'h0001);
        wr({2'b00, `DRS_P_METHOD}, 16'h0000);
        $display("test methods done");
        wr({2'b00, `DRS_P_DETMS}, 16'h0002);
        wr({2'b00, `DRS_P_HOLDMS}, 16'h0003);
        wr({2'b00, `DRS_P_OFFMS}, 16'h0004);
        wr({2'b00, `DRS_P_MAXREF}, 16'hffff);
        for (int s = 0; s < 3; s++) begin
            wr({2'b00, `DRS_P_RUNSRC}, 16'(s));
            wr({2'b00, `DRS_P_REFSRC}, 16'(s));
            r = 16'($urandom);
            drive(2'((s + 1) % 3), 1'b1, r);
            repeat (10) @(negedge clk);
            chk({15'h0, outEnable_r}, 16'h0000);
            drive(2'(s), 1'b1, r);
            waitOut(1'b1, 8);
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk(appliedRef_r, r);
            rd(`DRS_A_APPREF, st);
            chk(st, r);
            drive(2'(s), 1'b0, r);
            waitOut(1'b0, 8 * TICK);
            chk(16'(n >= 3 * TICK), 16'h0001);
            drive(2'(s), 1'b1, r);
            waitOut(1'b1, 8);
            drive(2'(s), 1'b0, r);
            waitOut(1'b0, 8 * TICK);
        end
        $display("test sources done");
        wr({2'b00, `DRS_P_MIXREF}, 16'h8000);
        for (int md = 1; md < 3; md++) begin
            wr({2'b00, `DRS_P_STOPMODE}, 16'(md));
            drive(2'd2, 1'b1, 16'h1234);
            waitOut(1'b1, 8);
            drive(2'd2, 1'b0, 16'h1234);
            waitOut(1'b0, 6 * TICK);
            chk(16'(n >= TICK && n <= 4 * TICK), 16'h0001);
            drive(2'd2, 1'b1, 16'h1234);
            waitOut(1'b1, 7 * TICK);
            chk(16'(n >= 3 * TICK), 16'h0001);
            drive(2'd2, 1'b0, 16'h1234);
            waitOut(1'b0, 6 * TICK);
            repeat (5 * TICK) @(posedge clk);
        end
        $display("test free run done");
        wr({2'b00, `DRS_P_STOPMODE}, 16'h0000);
        wr({2'b00, `DRS_P_RUNSRC}, 16'h0001);
        wr({2'b00, `DRS_P_REFSRC}, 16'h0001);
        wr({2'b00, `DRS_P_RAMPEN}, 16'h0001);
        wr({2'b00, `DRS_P_ACCSW1}, 16'h4000);
        wr({2'b00, `DRS_P_ACCSW2}, 16'h8000);
        for (int k = 0; k < 3; k++) begin
            wr(7'({2'b00, `DRS_P_ACCT1} + k), 16'h0001);
        end
        ramp(16'h0000, 16384 * 50 / 1000, 40);
        ramp(16'h0001, 16384 * 50 / 10000, 6);
        $display("test ramp done");
        wr(`DRS_A_DIFUNC0, `DRS_DI_MOTOR);
        @(posedge clk);
        diPins <= 4'h1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({15'h0, motorSel_r}, 16'h0001);
        rd(`DRS_A_STATUS, st);
        chk({15'h0, st[7]}, 16'h0001);
        $display("test motor select done");
        testDone();
    end
endmodule : tb
